// ==== setc_pkg.sv ====
// Purpose: shared constants and types for the sensor enable and timing control
// Assumes: 200 MHz system clock
// Notes:   phase times are counted in clock cycles derived from nanoseconds
package setc_pkg;
  localparam int CLK_NS        = 5;
  localparam int ALS_STEP_NS   = 2780000;
  localparam int ALS_STEP_CYC  = ALS_STEP_NS / CLK_NS;
  localparam int PROX_STEP_NS  = 88000;
  localparam int PROX_STEP_CYC = PROX_STEP_NS / CLK_NS;
  localparam logic [3:0] LONG_WAIT_MULT = 4'hC;
  localparam logic [3:0] UNIT_MULT      = 4'h1;

  localparam logic [6:0] DEV_ADDR = 7'h39;

  localparam logic [7:0] CTL_OFS = 8'h80;
  localparam logic [7:0] LIT_OFS = 8'h81;
  localparam logic [7:0] PSP_OFS = 8'h82;
  localparam logic [7:0] LWT_OFS = 8'h83;
  localparam logic [7:0] PWT_OFS = 8'hA9;

  localparam logic [7:0] CTL_RST = 8'h00;
  localparam logic [7:0] LIT_RST = 8'h00;
  localparam logic [7:0] PSP_RST = 8'h1F;
  localparam logic [7:0] LWT_RST = 8'h00;
  localparam logic [7:0] PWT_RST = 8'h00;

  localparam int PWR_BIT = 0;
  localparam int LFE_BIT = 1;
  localparam int PFE_BIT = 2;
  localparam int LWE_BIT = 3;
  localparam int PWE_BIT = 4;

  typedef enum logic [4:0] {
    SEQ_IDLE  = 5'h01,
    SEQ_PROX  = 5'h02,
    SEQ_PWAIT = 5'h04,
    SEQ_LINT  = 5'h08,
    SEQ_LWAIT = 5'h10
  } setc_seq_t;

  typedef enum logic [6:0] {
    I2_IDLE  = 7'h01,
    I2_ADDR  = 7'h02,
    I2_AACK  = 7'h04,
    I2_WBYTE = 7'h08,
    I2_WACK  = 7'h10,
    I2_RBYTE = 7'h20,
    I2_RACK  = 7'h40
  } setc_i2c_t;
endpackage

// ==== setc_rb_if.sv ====
// Purpose: register access path between the serial slave and the register file
// Assumes: single clock, write is a one-cycle pulse
// Notes:   read data is combinational from the current address
`timescale 1ns/1ps
interface setc_rb_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic [7:0] rdata;
  modport master (output addr, output wdata, output wr, input rdata);
  modport slave  (input addr, input wdata, input wr, output rdata);
endinterface

// ==== setc_timer.sv ====
// Purpose: phase down counter, (load+1) * mult steps of STEP cycles
// Assumes: start and abort are one-cycle pulses, abort wins
// Notes:   done is combinational so the sequencer can chain phases without a gap
`timescale 1ns/1ps
module setc_timer #(
  parameter int STEP = 556000
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       start,
  input  wire logic       abort,
  input  wire logic [7:0] load,
  input  wire logic [3:0] mult,
  output logic            busy,
  output logic            done
);
  localparam int PW = $clog2(STEP + 1);
  localparam logic [PW-1:0] PRE_TOP = PW'(STEP - 1);

  logic [PW-1:0] pre_q;
  logic [3:0]    sub_q;
  logic [7:0]    cnt_q;
  logic [7:0]    ld_q;
  logic [3:0]    ml_q;
  logic [31:0]   el_q;

  assign done = busy && pre_q == '0 && sub_q == 4'h0 && cnt_q == 8'h00;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy  <= 1'b0;
      pre_q <= '0;
      sub_q <= 4'h0;
      cnt_q <= 8'h00;
    end else if (abort) begin
      busy <= 1'b0;
    end else if (start) begin
      busy  <= 1'b1;
      cnt_q <= load;
      sub_q <= mult - 4'h1;
      pre_q <= PRE_TOP;
    end else if (busy) begin
      if (pre_q == '0) begin
        pre_q <= PRE_TOP;
        if (sub_q == 4'h0) begin
          sub_q <= ml_q - 4'h1;
          // terminal count is zero, so a load of 0 still runs one pass of mult steps
          if (cnt_q == 8'h00) busy <= 1'b0;
          else cnt_q <= cnt_q - 8'h01;
        end else begin
          sub_q <= sub_q - 4'h1;
        end
      end else begin
        pre_q <= pre_q - PW'(1);
      end
    end
  end

  // helper for the exact-length check below
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      el_q <= 32'h0;
      ld_q <= 8'h00;
      ml_q <= 4'h1;
    end else if (start) begin
      el_q <= 32'h0;
      ld_q <= load;
      ml_q <= mult;
    end else if (busy) begin
      el_q <= el_q + 32'h1;
    end
  end

  dur_exact_a: assert property (@(posedge clk) disable iff (rst)
    done |-> el_q + 32'h1 == 32'(({24'h0, ld_q} + 32'h1) * {28'h0, ml_q} * STEP))
    else $error("phase length differs from (load+1)*mult*step");
endmodule

// ==== setc_i2c.sv ====
// Purpose: two-wire serial register slave with auto-incrementing pointer
// Assumes: bus pins are synchronous to the clock
// Notes:   pointer survives stop, so a bare read continues at last address + 1
`timescale 1ns/1ps
module setc_i2c
  import setc_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic scl,
  input  wire logic sda_in,
  output logic      sda_oe_n,
  setc_rb_if.master rb
);
  setc_i2c_t  st_q;
  logic       scl_q, sda_q, scl_p, sda_p;
  logic [7:0] sh_q, ptr_q, wd_q;
  logic [3:0] bitc_q;
  logic       rw_q, first_q, wr_q;
  logic       rise, fall, start_c, stop_c;

  assign rise    = scl_q & ~scl_p;
  assign fall    = ~scl_q & scl_p;
  assign start_c = scl_q & scl_p & sda_p & ~sda_q;
  assign stop_c  = scl_q & scl_p & ~sda_p & sda_q;
  assign rb.addr  = ptr_q;
  assign rb.wdata = wd_q;
  assign rb.wr    = wr_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      scl_p <= 1'b1;
      sda_p <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda_in;
      scl_p <= scl_q;
      sda_p <= sda_q;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q     <= I2_IDLE;
      sh_q     <= 8'h00;
      ptr_q    <= 8'h00;
      wd_q     <= 8'h00;
      bitc_q   <= 4'h0;
      rw_q     <= 1'b0;
      first_q  <= 1'b0;
      wr_q     <= 1'b0;
      sda_oe_n <= 1'b1;
    end else begin
      wr_q <= 1'b0;
      if (wr_q) ptr_q <= ptr_q + 8'h01;
      if (stop_c) begin
        st_q     <= I2_IDLE;
        sda_oe_n <= 1'b1;
      end else if (start_c) begin
        st_q     <= I2_ADDR;
        bitc_q   <= 4'h0;
        sda_oe_n <= 1'b1;
      end else if (rise) begin
        case (st_q)
          I2_ADDR, I2_WBYTE: begin
            sh_q   <= {sh_q[6:0], sda_q};
            bitc_q <= bitc_q + 4'h1;
          end
          // master nack ends the read
          I2_RACK: if (sda_q) st_q <= I2_IDLE;
          default: ;
        endcase
      end else if (fall) begin
        case (st_q)
          I2_ADDR: if (bitc_q == 4'h8) begin
            if (sh_q[7:1] == DEV_ADDR) begin
              st_q     <= I2_AACK;
              rw_q     <= sh_q[0];
              sda_oe_n <= 1'b0;
            end else begin
              st_q <= I2_IDLE;
            end
          end
          I2_WBYTE: if (bitc_q == 4'h8) begin
            st_q     <= I2_WACK;
            sda_oe_n <= 1'b0;
            first_q  <= 1'b0;
            if (first_q) begin
              ptr_q <= sh_q;
            end else begin
              wr_q <= 1'b1;
              wd_q <= sh_q;
            end
          end
          I2_WACK: begin
            st_q     <= I2_WBYTE;
            bitc_q   <= 4'h0;
            sda_oe_n <= 1'b1;
          end
          I2_RBYTE: if (bitc_q == 4'h8) begin
            st_q     <= I2_RACK;
            sda_oe_n <= 1'b1;
          end else begin
            sda_oe_n <= sh_q[7];
            sh_q     <= {sh_q[6:0], 1'b0};
            bitc_q   <= bitc_q + 4'h1;
          end
          I2_AACK, I2_RACK: begin
            if (st_q == I2_AACK && !rw_q) begin
              st_q     <= I2_WBYTE;
              bitc_q   <= 4'h0;
              first_q  <= 1'b1;
              sda_oe_n <= 1'b1;
            end else begin
              st_q     <= I2_RBYTE;
              sh_q     <= {rb.rdata[6:0], 1'b0};
              sda_oe_n <= rb.rdata[7];
              ptr_q    <= ptr_q + 8'h01;
              bitc_q   <= 4'h1;
            end
          end
          default: ;
        endcase
      end
    end
  end
endmodule

// ==== setc_top.sv ====
// Function
// - power-on bit runs oscillator and converters; cleared, everything stays idle
// - light function bit enables ambient light integration phase
// - proximity function bit enables proximity sample phase
// - light wait bit inserts light wait phase timed by light wait register
// - proximity wait bit inserts proximity wait phase timed by its register
// - integration is a down counter to zero, (value+1) steps of 2.78 ms
// - proximity sample lasts (value+1) times 88 us; register resets to 1F
// - light wait is a down counter, (value+1) steps of 2.78 ms
// - long wait option stretches light wait twelvefold
//
// Purpose: enable register, timing registers and phase sequencer of a light
//          and proximity sensor, configured over the two-wire serial bus
// Assumes: serial pins synchronous to CLK; proximity wait steps like light wait
// Notes:   phase order proximity, proximity wait, integration, light wait
`timescale 1ns/1ps
module setc_top
  import setc_pkg::*;
#(
  parameter int ALS_STEP  = ALS_STEP_CYC,
  parameter int PROX_STEP = PROX_STEP_CYC
) (
  input  wire logic CLK,
  input  wire logic RESET,
  input  wire logic SCL,
  input  wire logic SDA_IN,
  output logic      SDA_OUT,
  output logic      SDA_OE_N,
  input  wire logic LONG_WAIT_OPTION,
  output logic      OSC_ADC_ON,
  output logic      PROX_SAMPLING,
  output logic      PROX_WAITING,
  output logic      LIGHT_INTEGRATING,
  output logic      LIGHT_WAITING,
  output logic      PROX_DONE,
  output logic      LIGHT_DONE
);
  setc_rb_if rb ();

  logic [7:0] ctl_q;
  logic [7:0] lit_q;
  logic [7:0] psp_q;
  logic [7:0] lwt_q;
  logic [7:0] pwt_q;
  setc_seq_t  st_q, st_d;
  logic       go;
  logic       abort;
  logic       ps_start, ps_busy, ps_done;
  logic       al_start, al_busy, al_done;
  logic [7:0] al_load;
  logic [3:0] al_mult;
  logic       ph_done;
  logic       pwr_on, lfe, pfe, lwe, pwe;
  logic [3:0] ring_en;
  logic       prox_done_q, light_done_q;

  assign pwr_on = ctl_q[PWR_BIT];
  assign lfe = ctl_q[LFE_BIT];
  assign pfe = ctl_q[PFE_BIT];
  assign lwe = ctl_q[LWE_BIT];
  assign pwe = ctl_q[PWE_BIT];
  assign ring_en = {lwe, lfe, pwe, pfe};

  // open-drain data pin: only ever pulled low
  assign SDA_OUT = 1'b0;
  assign OSC_ADC_ON = ctl_q[PWR_BIT];
  assign PROX_SAMPLING     = st_q[1];
  assign PROX_WAITING      = st_q[2];
  assign LIGHT_INTEGRATING = st_q[3];
  assign LIGHT_WAITING     = st_q[4];
  assign PROX_DONE  = prox_done_q;
  assign LIGHT_DONE = light_done_q;

  setc_i2c u_i2c (
    .clk      (CLK),
    .rst      (RESET),
    .scl      (SCL),
    .sda_in   (SDA_IN),
    .sda_oe_n (SDA_OE_N),
    .rb       (rb.master)
  );

  // register file; reserved enable bits are stored as written
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      ctl_q <= CTL_RST;
      lit_q <= LIT_RST;
      psp_q <= PSP_RST;
      lwt_q <= LWT_RST;
      pwt_q <= PWT_RST;
    end else if (rb.wr) begin
      if (rb.addr == CTL_OFS) ctl_q <= rb.wdata;
      else if (rb.addr == LIT_OFS) lit_q <= rb.wdata;
      else if (rb.addr == PSP_OFS) psp_q <= rb.wdata;
      else if (rb.addr == LWT_OFS) lwt_q <= rb.wdata;
      else if (rb.addr == PWT_OFS) pwt_q <= rb.wdata;
    end
  end

  always_comb begin
    if (rb.addr == CTL_OFS) rb.rdata = ctl_q;
    else if (rb.addr == LIT_OFS) rb.rdata = lit_q;
    else if (rb.addr == PSP_OFS) rb.rdata = psp_q;
    else if (rb.addr == LWT_OFS) rb.rdata = lwt_q;
    else if (rb.addr == PWT_OFS) rb.rdata = pwt_q;
    else rb.rdata = 8'h00;
  end

  // next enabled phase in ring order, starting at slot s
  function automatic setc_seq_t ring(input logic [3:0] en, input int s);
    setc_seq_t r;
    int        k;
    r = SEQ_IDLE;
    for (k = 3; k >= 0; k--) begin
      if (en[(s + k) % 4]) begin
        case ((s + k) % 4)
          0: r = SEQ_PROX;
          1: r = SEQ_PWAIT;
          2: r = SEQ_LINT;
          default: r = SEQ_LWAIT;
        endcase
      end
    end
    return r;
  endfunction

  assign ph_done = (st_q == SEQ_PROX) ? ps_done : al_done;

  always_comb begin
    st_d  = st_q;
    go    = 1'b0;
    abort = 1'b0;
    // waits alone are pointless, so a cycle needs at least one function
    if (!pwr_on || !(pfe || lfe)) begin
      st_d  = SEQ_IDLE;
      abort = st_q != SEQ_IDLE;
    end else if ((st_q == SEQ_PROX && !pfe) || (st_q == SEQ_LINT && !lfe)) begin
      st_d  = SEQ_IDLE;
      abort = 1'b1;
    end else begin
      case (st_q)
        SEQ_IDLE: begin
          st_d = ring(ring_en, 0);
          go   = 1'b1;
        end
        SEQ_PROX: if (ph_done) begin
          st_d = ring(ring_en, 1);
          go   = 1'b1;
        end
        SEQ_PWAIT: if (ph_done) begin
          st_d = ring(ring_en, 2);
          go   = 1'b1;
        end
        SEQ_LINT: if (ph_done) begin
          st_d = ring(ring_en, 3);
          go   = 1'b1;
        end
        SEQ_LWAIT: if (ph_done) begin
          st_d = ring(ring_en, 0);
          go   = 1'b1;
        end
        default: st_d = SEQ_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) st_q <= SEQ_IDLE;
    else st_q <= st_d;
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      prox_done_q  <= 1'b0;
      light_done_q <= 1'b0;
    end else begin
      prox_done_q  <= st_q == SEQ_PROX && ps_done && !abort;
      light_done_q <= st_q == SEQ_LINT && al_done && !abort;
    end
  end

  assign ps_start = go && st_d == SEQ_PROX;
  assign al_start = go && (st_d == SEQ_PWAIT || st_d == SEQ_LINT || st_d == SEQ_LWAIT);

  always_comb begin
    al_mult = UNIT_MULT;
    if (st_d == SEQ_LINT) al_load = lit_q;
    else if (st_d == SEQ_LWAIT) al_load = lwt_q;
    else al_load = pwt_q;
    if (st_d == SEQ_LWAIT && LONG_WAIT_OPTION) al_mult = LONG_WAIT_MULT;
  end

  // one prescaled counter per step size; both share the ring sequencer
  setc_timer #(.STEP(PROX_STEP)) u_ps (
    .clk   (CLK),
    .rst   (RESET),
    .start (ps_start),
    .abort (abort),
    .load  (psp_q),
    .mult  (UNIT_MULT),
    .busy  (ps_busy),
    .done  (ps_done)
  );

  setc_timer #(.STEP(ALS_STEP)) u_al (
    .clk   (CLK),
    .rst   (RESET),
    .start (al_start),
    .abort (abort),
    .load  (al_load),
    .mult  (al_mult),
    .busy  (al_busy),
    .done  (al_done)
  );

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  sequence lw_entry;
    st_q != SEQ_LWAIT ##1 st_q == SEQ_LWAIT;
  endsequence

  sequence pw_entry;
    st_q != SEQ_PWAIT ##1 st_q == SEQ_PWAIT;
  endsequence

  power_gate_a: assert property (!pwr_on |=> st_q == SEQ_IDLE && !ps_busy && !al_busy)
    else $error("phase active while power-on bit is low");
  light_gate_a: assert property (!lfe |=> st_q != SEQ_LINT)
    else $error("integration runs with light function off");
  prox_gate_a: assert property (!pfe |=> st_q != SEQ_PROX)
    else $error("sampling runs with proximity function off");
  lwait_bit_a: assert property (lw_entry |-> $past(lwe))
    else $error("light wait entered with its bit clear");
  pwait_bit_a: assert property (pw_entry |-> $past(pwe))
    else $error("proximity wait entered with its bit clear");
  integ_load_a: assert property (al_start && st_d == SEQ_LINT |-> al_load == lit_q
    && al_mult == UNIT_MULT ##1 st_q == SEQ_LINT && al_busy)
    else $error("integration not loaded from its register");
  sample_load_a: assert property (ps_start |=> st_q == SEQ_PROX && ps_busy
    && !al_busy)
    else $error("proximity sample did not start");
  lwait_load_a: assert property (al_start && st_d == SEQ_LWAIT |-> al_load == lwt_q)
    else $error("light wait not loaded from its register");
  long_mult_a: assert property (al_start && st_d == SEQ_LWAIT
    |-> al_mult == (LONG_WAIT_OPTION ? LONG_WAIT_MULT : UNIT_MULT))
    else $error("light wait multiplier wrong");
  abort_idle_a: assert property ((st_q == SEQ_LINT && !lfe)
    |=> st_q == SEQ_IDLE && !al_busy && !LIGHT_DONE)
    else $error("integration not stopped when its bit dropped");

  sequence lint_entry;
    st_q != SEQ_LINT ##1 st_q == SEQ_LINT;
  endsequence

  sequence prox_entry;
    st_q != SEQ_PROX ##1 st_q == SEQ_PROX;
  endsequence

  // a phase is entered only with power and its own bit seen the cycle before
  lint_bit_a: assert property (lint_entry |-> $past(lfe && pwr_on))
    else $error("integration entered with its bits clear");
  prox_bit_a: assert property (prox_entry |-> $past(pfe && pwr_on))
    else $error("sampling entered with its bits clear");
  pwait_load_a: assert property (al_start && st_d == SEQ_PWAIT
    |-> al_load == pwt_q && al_mult == UNIT_MULT)
    else $error("proximity wait not loaded from its register");
  power_up_a: assert property ($rose(pwr_on) && (pfe || lfe) |=> st_q != SEQ_IDLE)
    else $error("no phase started after power-on");
  wait_only_a: assert property (pwr_on && !pfe && !lfe |=> st_q == SEQ_IDLE)
    else $error("wait phase ran with no function enabled");

  // each phase holds until its own counter ends, so a phase cut short shows here
  prox_hold_a: assert property (st_q == SEQ_PROX && !ps_done && pfe && pwr_on
    |=> st_q == SEQ_PROX)
    else $error("sample left before its count ended");
  pwait_hold_a: assert property (st_q == SEQ_PWAIT && !al_done && pwr_on
    && (pfe || lfe) |=> st_q == SEQ_PWAIT)
    else $error("proximity wait left before its count ended");
  lint_hold_a: assert property (st_q == SEQ_LINT && !al_done && lfe && pwr_on
    |=> st_q == SEQ_LINT)
    else $error("integration left before its count ended");
  lwait_hold_a: assert property (st_q == SEQ_LWAIT && !al_done && pwr_on
    && (pfe || lfe) |=> st_q == SEQ_LWAIT)
    else $error("light wait left before its count ended");

  // exactly one counter runs per phase; idle leaves both stopped
  prox_timer_a: assert property (st_q == SEQ_PROX |-> ps_busy && !al_busy)
    else $error("sample phase without its counter");
  light_timer_a: assert property (st_q inside {SEQ_PWAIT, SEQ_LINT, SEQ_LWAIT}
    |-> al_busy && !ps_busy)
    else $error("light or wait phase without its counter");
  idle_timers_a: assert property (st_q == SEQ_IDLE |-> !ps_busy && !al_busy)
    else $error("counter runs while idle");

  // done pulses follow a completed phase only
  prox_done_a: assert property (st_q == SEQ_PROX && ps_done && pfe && pwr_on
    |=> PROX_DONE)
    else $error("no done pulse after a sample");
  light_done_a: assert property (st_q == SEQ_LINT && al_done && lfe && pwr_on
    |=> LIGHT_DONE)
    else $error("no done pulse after integration");
  idle_done_a: assert property (st_q == SEQ_IDLE |=> !PROX_DONE && !LIGHT_DONE)
    else $error("done pulse while idle");
endmodule

// ==== setc_host_model.sv ====
// Purpose: two-wire bus host that configures the sensor registers
// Assumes: open-drain data line with pull-up, resolved by the bench
// Notes:   slow fixed bit rate, every bus level is held HALF clock cycles
`timescale 1ns/1ps
module setc_host_model
  import setc_pkg::*;
#(
  parameter int HALF = 6
) (
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_oe_n
);
  initial begin
    scl      = 1'b1;
    sda_oe_n = 1'b1;
  end

  task automatic hold();
    repeat (HALF) @(negedge clk);
  endtask

  // also serves as repeated start: data is released before the clock rises
  task automatic start();
    sda_oe_n = 1'b1;
    hold();
    scl = 1'b1;
    hold();
    sda_oe_n = 1'b0;
    hold();
    scl = 1'b0;
    hold();
  endtask

  task automatic stop();
    sda_oe_n = 1'b0;
    hold();
    scl = 1'b1;
    hold();
    sda_oe_n = 1'b1;
    hold();
  endtask

  // data moves only while the clock is low, so no bit can read as start or stop
  task automatic xfer(input logic [7:0] tx, input logic ack_in,
                      output logic [7:0] rx, output logic ack_out);
    logic [8:0] sh;
    sh = {tx, ack_in};
    for (int i = 8; i >= 0; i--) begin
      sda_oe_n = sh[i];
      hold();
      scl = 1'b1;
      hold();
      sh[i] = sda;
      scl = 1'b0;
      hold();
    end
    rx      = sh[8:1];
    ack_out = sh[0];
  endtask

  task automatic wr(input logic [7:0] ofs, input logic [7:0] data, output logic [2:0] acks);
    logic [7:0] rx;
    start();
    xfer({DEV_ADDR, 1'b0}, 1'b1, rx, acks[2]);
    xfer(ofs, 1'b1, rx, acks[1]);
    xfer(data, 1'b1, rx, acks[0]);
    stop();
  endtask

  // single byte read, host refuses further bytes
  task automatic rd(input logic [7:0] ofs, output logic [7:0] data, output logic [2:0] acks);
    logic [7:0] rx;
    logic       nak;
    start();
    xfer({DEV_ADDR, 1'b0}, 1'b1, rx, acks[2]);
    xfer(ofs, 1'b1, rx, acks[1]);
    start();
    xfer({DEV_ADDR, 1'b1}, 1'b1, rx, acks[0]);
    xfer(8'hFF, 1'b1, data, nak);
    stop();
  endtask
endmodule

// ==== sensor_enable_timing_ctrl_tb.sv ====
// Purpose: self-checking bench for the enable register and phase timing
// Assumes: shortened step counts, all timing derived from ALS and PRX
// Notes:   phase lengths are measured at the falling clock edge
`timescale 1ns/1ps
`define CHK(act, exp) check(32'(act), 32'(exp))
module sensor_enable_timing_ctrl_tb
  import setc_pkg::*;
;
  localparam int ALS = 4;
  localparam int PRX = 3;

  logic       clk;
  logic       reset;
  logic       scl;
  logic       host_oe_n;
  logic       dev_oe_n;
  logic       sda;
  logic       sda_out;
  logic       long_wait;
  logic       osc_on;
  logic [3:0] ph;
  logic       prox_done;
  logic       light_done;
  logic       run_on;
  logic [3:0] want;
  logic       brk;
  logic [7:0] ens [6] = '{8'h1F, 8'h1F, 8'h13, 8'h05, 8'h15, 8'h1E};
  int         run [4];
  int         last [4];
  int         seen [4];
  int         n_pdone;
  int         n_ldone;
  int         miscompares;
  int         n_compared;

  // pull-up: the line is low while either party pulls it
  assign sda = host_oe_n & dev_oe_n;

  setc_top #(.ALS_STEP(ALS), .PROX_STEP(PRX)) dut (
    .CLK(clk), .RESET(reset), .SCL(scl), .SDA_IN(sda), .SDA_OUT(sda_out),
    .SDA_OE_N(dev_oe_n), .LONG_WAIT_OPTION(long_wait), .OSC_ADC_ON(osc_on),
    .PROX_SAMPLING(ph[0]), .PROX_WAITING(ph[1]), .LIGHT_INTEGRATING(ph[2]),
    .LIGHT_WAITING(ph[3]), .PROX_DONE(prox_done), .LIGHT_DONE(light_done)
  );

  setc_host_model host (.clk(clk), .sda(sda), .scl(scl), .sda_oe_n(host_oe_n));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(negedge clk) begin
    for (int i = 0; i < 4; i++) begin
      // a phase that repeats with no gap is split at its done pulse
      brk = (i == 0 && prox_done === 1'b1) || (i == 2 && light_done === 1'b1);
      if (run[i] != 0 && (brk || ph[i] !== 1'b1)) begin
        last[i] = run[i];
        seen[i]++;
        run[i] = 0;
      end
      if (ph[i] === 1'b1) run[i]++;
    end
    if (prox_done === 1'b1) n_pdone++;
    if (light_done === 1'b1) n_ldone++;
  end

  task automatic check(input logic [31:0] act, input logic [31:0] exp);
    n_compared++;
    if (act !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, act, exp);
    end
  endtask

  task automatic clear_stats();
    @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      run[i]  = 0;
      last[i] = 0;
      seen[i] = 0;
    end
    n_pdone = 0;
    n_ldone = 0;
  endtask

  task automatic wr_reg(input logic [7:0] ofs, input logic [7:0] d);
    logic [2:0] acks;
    host.wr(ofs, d, acks);
    `CHK(acks, 3'h0);
  endtask

  task automatic rd_chk(input logic [7:0] ofs, input logic [7:0] exp);
    logic [2:0] acks;
    logic [7:0] d;
    host.rd(ofs, d, acks);
    `CHK(acks, 3'h0);
    `CHK(d, exp);
  endtask

  task automatic conclude();
    $display("compared %0d, wrong %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // whole run is about 21000 cycles; a hang is cut off well beyond that
  initial begin
    repeat (60000) @(posedge clk);
    miscompares++;
    conclude();
  end

  initial begin
    reset     = 1'b1;
    long_wait = 1'b0;
    repeat (12) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    rd_chk(CTL_OFS, 8'h00);
    rd_chk(LIT_OFS, 8'h00);
    rd_chk(PSP_OFS, 8'h1F);
    rd_chk(LWT_OFS, 8'h00);
    `CHK(sda_out, 1'b0);
    $display("test reset_values done");
    // timing set up before any function bit goes high
    wr_reg(LIT_OFS, 8'h02);
    wr_reg(PSP_OFS, 8'h01);
    wr_reg(LWT_OFS, 8'h01);
    wr_reg(PWT_OFS, 8'h00);
    wr_reg(8'h84, 8'h55);
    rd_chk(LIT_OFS, 8'h02);
    rd_chk(PSP_OFS, 8'h01);
    rd_chk(LWT_OFS, 8'h01);
    rd_chk(8'h84, 8'h00);
    $display("test register_access done");
    clear_stats();
    wr_reg(CTL_OFS, 8'h01);
    repeat (100) @(negedge clk);
    `CHK(osc_on, 1'b1);
    `CHK(seen[0] + seen[1] + seen[2] + seen[3], 0);
    wr_reg(CTL_OFS, 8'h00);
    `CHK(osc_on, 1'b0);
    $display("test power_only done");
    for (int k = 0; k < 6; k++) begin
      wr_reg(CTL_OFS, 8'h00);
      long_wait = (k == 1);
      clear_stats();
      wr_reg(CTL_OFS, ens[k]);
      repeat (400) @(negedge clk);
      run_on = ens[k][0] & (ens[k][1] | ens[k][2]);
      want   = {run_on & ens[k][3], run_on & ens[k][1], run_on & ens[k][4], run_on & ens[k][2]};
      `CHK(seen[0] != 0, want[0]);
      `CHK(seen[1] != 0, want[1]);
      `CHK(seen[2] != 0, want[2]);
      `CHK(seen[3] != 0, want[3]);
      if (want[0]) `CHK(last[0], 2 * PRX);
      if (want[1]) `CHK(last[1], ALS);
      if (want[2]) `CHK(last[2], 3 * ALS);
      if (want[3]) `CHK(last[3], 2 * ALS * (k == 1 ? 12 : 1));
      `CHK(n_pdone, seen[0]);
      `CHK(n_ldone, seen[2]);
      `CHK(osc_on, ens[k][0]);
      $display("test mode %0d done", k);
    end
    // long integration so that dropping its bit lands mid-phase
    wr_reg(CTL_OFS, 8'h00);
    wr_reg(LIT_OFS, 8'hFF);
    clear_stats();
    wr_reg(CTL_OFS, 8'h17);
    wr_reg(CTL_OFS, 8'h15);
    repeat (100) @(negedge clk);
    `CHK(seen[2], 1);
    `CHK(n_ldone, 0);
    `CHK(ph[2], 1'b0);
    `CHK(seen[0] != 0, 1'b1);
    `CHK(n_pdone, seen[0]);
    wr_reg(CTL_OFS, 8'h00);
    $display("test light_abort done");
    conclude();
  end
endmodule
